// ### ehm_pkg.sv
// Purpose: shared widths for the embedded hard multiplier block
// Assumes: one clock domain, active-low asynchronous clear
// Notes:   full operand is two equal lanes; product is twice as wide
package ehm_pkg;
  localparam int OP_W   = 18;          // full operand width
  localparam int LANE_W = 9;           // one lane in dual mode
  localparam int PR_W   = 2 * OP_W;    // full product width
  localparam int LPR_W  = 2 * LANE_W;  // one lane product width
  localparam logic [OP_W-1:0] OP_RST = 18'h00000;  // operand clear value
  localparam logic [PR_W-1:0] PR_RST = 36'h000000000; // product clear
  localparam logic            SG_RST = 1'b0;       // sign clear value
endpackage : ehm_pkg

// ### ehm_mult.sv
// Purpose: one hard multiplier, 18x18 or two 9x9, with optional registers
// Assumes: operands and controls are synchronous to clk
// Notes:   rst_n is the shared asynchronous clear of every register;
//          bypassed output stages pass the product combinationally
//
// How it works
// - one 18x18 or two 9x9 multipliers
// - each operand registered or bypassed per section
// - bypass choice independent for every operand
// - input registers have clock, enable, clear
// - all registers share clock, enable, clear
// - sign select high means operand is signed
// - product signed if any operand signed
// - optional output registers on the product
// - dual mode lanes share one sign pair
`timescale 1ns/1ps
module ehm_mult (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ena,
  input  wire logic                     mode_dual,
  input  wire logic                     a_reg_en,
  input  wire logic                     b_reg_en,
  input  wire logic                     sign_reg_en,
  input  wire logic                     out_reg_en,
  input  wire logic [ehm_pkg::OP_W-1:0] data_a,
  input  wire logic [ehm_pkg::OP_W-1:0] data_b,
  input  wire logic                     sign_a,
  input  wire logic                     sign_b,
  output logic      [ehm_pkg::PR_W-1:0] result
);
  localparam int OW = ehm_pkg::OP_W;
  localparam int LW = ehm_pkg::LANE_W;
  localparam int PW = ehm_pkg::PR_W;
  localparam int QW = ehm_pkg::LPR_W;

  logic [OW-1:0] a_q, b_q, next_a_q, next_b_q;
  logic          sa_q, sb_q, next_sa_q, next_sb_q;
  logic [PW-1:0] p_q, next_p_q;
  logic [OW-1:0] op_a, op_b;
  logic          sa, sb;
  logic [PW-1:0] prod;

  // next values of all registers: load only while the shared enable is high
  always_comb begin
    next_a_q  = a_q;
    next_b_q  = b_q;
    next_sa_q = sa_q;
    next_sb_q = sb_q;
    next_p_q  = p_q;
    if (ena) begin
      next_a_q  = data_a;
      next_b_q  = data_b;
      next_sa_q = sign_a;
      next_sb_q = sign_b;
      next_p_q  = prod;
    end
  end

  // one clock, one clear for every stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_q  <= ehm_pkg::OP_RST;
      b_q  <= ehm_pkg::OP_RST;
      sa_q <= ehm_pkg::SG_RST;
      sb_q <= ehm_pkg::SG_RST;
      p_q  <= ehm_pkg::PR_RST;
    end else begin
      a_q  <= next_a_q;
      b_q  <= next_b_q;
      sa_q <= next_sa_q;
      sb_q <= next_sb_q;
      p_q  <= next_p_q;
    end
  end

  // operand selection; A and B each choose register or bypass by themselves, both signs share sign_reg_en
  assign op_a = a_reg_en ? a_q : data_a;
  assign op_b = b_reg_en ? b_q : data_b;
  assign sa   = sign_reg_en ? sa_q : sign_a;
  assign sb   = sign_reg_en ? sb_q : sign_b;

  // multiplier stage: extend each operand by its sign, keep full width
  always_comb begin
    logic signed [OW:0]   xa, xb;
    logic signed [2*OW+1:0] pf;
    logic signed [LW:0]   la, lb, ha, hb;
    logic signed [2*LW+1:0] pl, ph;
    xa = $signed({sa & op_a[OW-1], op_a});
    xb = $signed({sb & op_b[OW-1], op_b});
    la = $signed({sa & op_a[LW-1], op_a[LW-1:0]});
    lb = $signed({sb & op_b[LW-1], op_b[LW-1:0]});
    ha = $signed({sa & op_a[OW-1], op_a[OW-1:LW]});
    hb = $signed({sb & op_b[OW-1], op_b[OW-1:LW]});
    pf = xa * xb;
    pl = la * lb;
    ph = ha * hb;
    if (mode_dual) begin
      prod = {ph[QW-1:0], pl[QW-1:0]};
    end else begin
      prod = pf[PW-1:0];
    end
  end

  // optional output stage over the whole product
  assign result = out_reg_en ? p_q : prod;

  // assertions guarding the datapath rules, sampled at the rising edge
  // a load edge followed by a cycle still on the registered path
  sequence s_load_out;
    out_reg_en && ena ##1 out_reg_en;
  endsequence

  // a cycle in which the shared enable is low
  sequence s_hold;
    !ena;
  endsequence

  // a frozen cycle followed by a cycle still on the registered path
  sequence s_freeze_out;
    out_reg_en && !ena ##1 out_reg_en;
  endsequence

  // registers come out of the clear at zero
  a_clear_zero: assert property (@(posedge clk)
    $rose(rst_n) |-> (a_q == '0 && b_q == '0 && p_q == '0))
    else $error("registers not zero after clear");

  // clear is asynchronous: every register reads zero while it is low
  a_clear_hold: assert property (@(posedge clk)
    !rst_n |-> (a_q == '0 && b_q == '0 && p_q == '0 && !sa_q && !sb_q))
    else $error("register not zero during clear");

  // a low enable freezes every stage at once
  a_hold_noena: assert property (@(posedge clk) disable iff (!rst_n)
    s_hold |=> ($stable(a_q) && $stable(b_q) && $stable(p_q)))
    else $error("register changed without enable");

  // operand registers load on an enabled edge
  a_reg_load: assert property (@(posedge clk) disable iff (!rst_n)
    ena |=> (a_q == $past(data_a) && b_q == $past(data_b)))
    else $error("input register failed to load");

  // sign registers follow the shared enable like the operands
  a_sign_load: assert property (@(posedge clk)
    disable iff (!rst_n)
    ena |=> (sa_q == $past(sign_a) && sb_q == $past(sign_b)))
    else $error("sign register failed to load");

  // A bypassed while B is registered
  a_bypass_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!a_reg_en && b_reg_en) |-> (op_a == data_a && op_b == b_q))
    else $error("operand routing wrong");

  // A registered while B is bypassed
  a_bypass_b: assert property (@(posedge clk)
    disable iff (!rst_n)
    (a_reg_en && !b_reg_en) |-> (op_a == a_q && op_b == data_b))
    else $error("operand routing wrong");

  // sign selects taken from their register when asked
  a_sign_route: assert property (@(posedge clk)
    disable iff (!rst_n)
    sign_reg_en |-> (sa == sa_q && sb == sb_q))
    else $error("sign routing wrong");

  // full width, both operands unsigned
  a_unsigned_full: assert property (@(posedge clk)
    disable iff (!rst_n)
    (!mode_dual && !sa && !sb) |-> prod == ({18'h0, op_a} * {18'h0, op_b}))
    else $error("unsigned full product wrong");

  // full width, both operands signed
  a_signed_full: assert property (@(posedge clk)
    disable iff (!rst_n)
    (!mode_dual && sa && sb) |->
      $signed(prod) == $signed(op_a) * $signed(op_b))
    else $error("signed full product wrong");

  // signed times unsigned: the product is signed
  a_mixed_full: assert property (@(posedge clk)
    disable iff (!rst_n)
    (!mode_dual && sa && !sb) |->
      $signed(prod) == $signed(op_a) * $signed({1'b0, op_b}))
    else $error("mixed sign product wrong");

  // dual lanes, both operands unsigned
  a_dual_lanes: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_dual && !sa && !sb) |->
      (prod[17:0] == {9'h0, op_a[8:0]} * {9'h0, op_b[8:0]} &&
       prod[35:18] == {9'h0, op_a[17:9]} * {9'h0, op_b[17:9]}))
    else $error("dual lane product wrong");

  // dual lanes, both operands signed through the one sign pair
  a_dual_signed: assert property (@(posedge clk)
    disable iff (!rst_n)
    (mode_dual && sa && sb) |->
      ($signed(prod[17:0]) == $signed(op_a[8:0]) * $signed(op_b[8:0]) &&
       $signed(prod[35:18]) == $signed(op_a[17:9]) * $signed(op_b[17:9])))
    else $error("signed dual lane product wrong");

  // dual lanes, unsigned A times signed B in the low lane
  a_dual_mixed: assert property (@(posedge clk)
    disable iff (!rst_n)
    (mode_dual && !sa && sb) |->
      $signed(prod[17:0]) == $signed({1'b0, op_a[8:0]}) * $signed(op_b[8:0]))
    else $error("mixed dual lane product wrong");

  // registered product is the one of the cycle before
  a_out_pipe: assert property (@(posedge clk) disable iff (!rst_n)
    s_load_out |-> result == $past(prod))
    else $error("registered product wrong");

  // frozen enable keeps a registered product on the output
  a_out_hold: assert property (@(posedge clk)
    disable iff (!rst_n)
    s_freeze_out |-> $stable(result))
    else $error("registered product moved without enable");

  // bypassed output shows the product at once
  a_out_bypass: assert property (@(posedge clk) disable iff (!rst_n)
    !out_reg_en |-> result == prod)
    else $error("bypassed product wrong");
endmodule : ehm_mult

// ### ehm_fab.sv
// Purpose: fabric model that supplies operands and sign selects
// Assumes: new values at a falling edge while step is high
// Notes:   one sign pair serves both lanes
`timescale 1ns/1ps
module ehm_fab (
  input  wire logic                     clk,
  input  wire logic                     step,
  input  wire logic                     ones,
  output logic      [ehm_pkg::OP_W-1:0] a = 18'h00000,
  output logic      [ehm_pkg::OP_W-1:0] b = 18'h00000,
  output logic                          sa = 1'b0,
  output logic                          sb = 1'b0
);
  // draw operands; all ones is the extreme corner
  always @(negedge clk)
    if (step) begin
      a  <= ones ? 18'h3ffff : 18'($urandom);
      b  <= ones ? 18'h3ffff : 18'($urandom);
      sa <= 1'($urandom);
      sb <= 1'($urandom);
    end
endmodule : ehm_fab

// ### testbench.sv
// Purpose: random self-checking bench for the hard multiplier
// Assumes: inputs change at the falling edge
// Notes:   expected values follow register and sign settings
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("FAIL %0t %h %h", $time, g, e); end end
module testbench;
  logic        clk = 1'b0, rst_n = 1'b0, step = 1'b0, ones = 1'b0;
  logic        ena = 1'b1, md = 1'b0, ar = 1'b0, br = 1'b0;
  logic        sr = 1'b0, orr = 1'b0, sa, sb, osa, osb, nsa, nsb;
  logic [17:0] da, db, oa, ob, na, nb;
  logic [35:0] res, ev, pv = 36'h000000000;
  int          n_fail = 0, cmp_count = 0;
  ehm_fab fab (.clk(clk), .step(step), .ones(ones), .a(da), .b(db),
    .sa(sa), .sb(sb));
  ehm_mult DUT (.clk(clk), .rst_n(rst_n), .ena(ena), .mode_dual(md),
    .a_reg_en(ar), .b_reg_en(br), .sign_reg_en(sr), .out_reg_en(orr),
    .data_a(da), .data_b(db), .sign_a(sa), .sign_b(sb), .result(res));
  // product with each operand widened by its own sign select
  function automatic logic [35:0] ex(logic [17:0] a, b, logic s, t);
    logic [17:0] l0, l1;
    l0 = $signed({s & a[8], a[8:0]}) * $signed({t & b[8], b[8:0]});
    l1 = $signed({s & a[17], a[17:9]}) * $signed({t & b[17], b[17:9]});
    if (md) return {l1, l0};
    return $signed({s & a[17], a}) * $signed({t & b[17], b});
  endfunction : ex
  // a register still shows the old value before its load edge
  function automatic logic held(logic r, int k);
    return k < 0 || (r && (k < 1 || !ena));
  endfunction : held
  function automatic logic [35:0] at(int k);
    return ex(held(ar, k) ? oa : na, held(br, k) ? ob : nb,
      held(sr, k) ? osa : nsa, held(sr, k) ? osb : nsb);
  endfunction : at
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // free running clock
  initial forever #20 clk = ~clk;
  // watchdog well beyond the expected run
  initial begin
    #200000 n_fail++;
    end_sim();
  end
  // random configurations, then a clear at the end of the run
  initial begin
    void'($urandom(37));
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (300) begin
      step <= 1'b1;
      @(negedge clk);
      step <= 1'b0;
      {oa, ob, osa, osb} = {da, db, sa, sb};
      {ena, md, ar, br, sr, orr} = 6'($urandom);
      ones <= ($urandom % 8 == 0);
      #1 {na, nb, nsa, nsb} = {da, db, sa, sb};
      for (int k = 0; k < 3; k++) begin
        ev = orr ? ((k < 1 || !ena) ? pv : at(k - 1)) : at(k);
        `CHK(res, ev)
        @(negedge clk);
      end
      ena = 1'b1;
      repeat (2) @(negedge clk);
      pv = ex(na, nb, nsa, nsb);
      `CHK(res, pv)
    end
    {ar, br, sr, orr} = 4'hf;
    repeat (3) @(negedge clk);
    rst_n = 1'b0;
    #1 `CHK(res, 36'h000000000)
    orr = 1'b0;
    #1 `CHK(res, 36'h000000000)
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    pv = ex(da, db, sa, sb);
    `CHK(res, pv)
    end_sim();
  end
endmodule : testbench
